// ===== rtl/gpio_params.svh
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

// ****************************************************************
// bank register layout
// ****************************************************************
`define GPIO_PINS_PER_BANK 8
`define GPIO_BANK_COUNT 2
`define GPIO_PIN_COUNT 16
`define GPIO_MODE_LSB 24
`define GPIO_DIR_LSB 16
`define GPIO_SF_LSB 8
`define GPIO_DATA_LSB 0

// ****************************************************************
// board pin positions in the second bank
// ****************************************************************
`define GPIO_LED_BIT 6
`define GPIO_BUTTON_BIT 5

// ****************************************************************
// reset values
// ****************************************************************
`define GPIO_BANK_A_RESET 32'h00000000
`define GPIO_BANK_C_RESET 32'h00400040
// pin drive groups {out, oe}; must repeat the bank reset words
`define GPIO_DRIVE_A_RESET 16'h0000
`define GPIO_DRIVE_C_RESET 16'h4040
`define GPIO_LED_RESET 1'h1

`endif

// ===== rtl/gpio_pkg.sv
`default_nettype none
package gpio_pkg;
	// per-bank register fields
	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] dir;
		logic [7:0] sf;
		logic [7:0] data;
	} bank_reg_s;

	// register write strobe with data
	typedef struct packed {
		logic wr_a;
		logic wr_c;
		logic [31:0] wdata;
	} bank_wr_s;

	// pin group, two signals per pin
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} pin_drive_s;
endpackage
`default_nettype wire

// ===== rtl/gpio_sync.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// two-flop level synchroniser
// ****************************************************************
module gpio_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] nxt_meta;
	logic [WIDTH-1:0] nxt_sync;

	// at least one bit to carry
	if (WIDTH < 1) begin : bad_width
		$error("synchroniser needs at least one bit");
	end

	// first stage is read only by the second
	always_comb begin
		nxt_meta = d;
		nxt_sync = meta_ff;
	end

	// registers only
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign q = sync_ff;
endmodule

`default_nettype wire

// ===== rtl/dual_bank_gpio_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "gpio_params.svh"

module dual_bank_gpio_port #(
	parameter int PINS_PER_BANK = `GPIO_PINS_PER_BANK
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire gpio_pkg::bank_wr_s bank_wr,
	output logic [31:0] gpio_bank_a,
	output logic [31:0] gpio_bank_c,
	input wire logic [7:0] pin_a_in,
	output gpio_pkg::pin_drive_s pin_a,
	input wire logic [7:0] pin_c_in,
	output gpio_pkg::pin_drive_s pin_c,
	output logic [7:0] special_c,
	output logic led_pin,
	output logic button_pressed
);
	// types for register words and pin groups
	import gpio_pkg::*;

	// ****************************************************************
	// elaboration check
	// ****************************************************************
	// refuse a bank width that the packed register layout cannot hold
	if (PINS_PER_BANK != `GPIO_PINS_PER_BANK) begin : bad_width
		$error("only eight pins per bank are supported");
	end

	// sixteen pins in total across the banks
	if (`GPIO_BANK_COUNT * PINS_PER_BANK != `GPIO_PIN_COUNT) begin : bad_count
		$error("bank count and bank width do not give the pin total");
	end

	// field positions must match the packed word
	if (`GPIO_MODE_LSB != `GPIO_DIR_LSB + PINS_PER_BANK) begin : bad_mode_lsb
		$error("mode field must sit above the direction field");
	end
	if (`GPIO_DIR_LSB != `GPIO_SF_LSB + PINS_PER_BANK) begin : bad_dir_lsb
		$error("direction field must sit above the special function field");
	end
	if (`GPIO_SF_LSB != `GPIO_DATA_LSB + PINS_PER_BANK) begin : bad_sf_lsb
		$error("special function field must sit above the data field");
	end
	if (`GPIO_DATA_LSB != 32'h0) begin : bad_data_lsb
		$error("data field must start at bit zero");
	end

	// board pins must be distinct pins of one bank
	if (`GPIO_LED_BIT >= PINS_PER_BANK) begin : bad_led_bit
		$error("led pin lies outside the bank");
	end
	if (`GPIO_BUTTON_BIT >= PINS_PER_BANK) begin : bad_button_bit
		$error("button pin lies outside the bank");
	end
	if (`GPIO_LED_BIT == `GPIO_BUTTON_BIT) begin : bad_board_pins
		$error("led and button cannot share a pin");
	end

	// bank A reset word may not carry special function bits
	if (((`GPIO_BANK_A_RESET >> `GPIO_SF_LSB) & 32'hFF) != 32'h0) begin : bad_a_reset
		$error("bank A reset word sets special function bits");
	end

	// drive reset words must repeat the data bytes of the bank reset words
	if (((`GPIO_DRIVE_A_RESET >> PINS_PER_BANK) != (`GPIO_BANK_A_RESET & 32'hFF)) ||
		((`GPIO_DRIVE_C_RESET >> PINS_PER_BANK) != (`GPIO_BANK_C_RESET & 32'hFF))) begin : bad_drv
		$error("drive reset values disagree with the bank reset words");
	end

	// ****************************************************************
	// helpers
	// ****************************************************************
	// pin drives only when plain output: mode 0, dir 1, sf 0
	function automatic logic [7:0] out_en(input bank_reg_s r);
		out_en = ~r.mode & r.dir & ~r.sf;
	endfunction

	// split a written word into fields; bank A has no special function bits
	function automatic bank_reg_s unpack_word(input logic [31:0] word, input logic has_sf);
		bank_reg_s r;
		r.mode = word[`GPIO_MODE_LSB +: `GPIO_PINS_PER_BANK];
		r.dir = word[`GPIO_DIR_LSB +: `GPIO_PINS_PER_BANK];
		r.sf = has_sf ? word[`GPIO_SF_LSB +: `GPIO_PINS_PER_BANK] : 8'h00;
		r.data = word[`GPIO_DATA_LSB +: `GPIO_PINS_PER_BANK];
		unpack_word = r;
	endfunction

	// levels arrive two edges late through the synchroniser
	// read word: config as stored, data bits show synchronised pin level
	function automatic logic [31:0] read_word(input bank_reg_s r, input logic [7:0] lvl);
		bank_reg_s w;
		w = r;
		w.data = lvl;
		read_word = w;
	endfunction

	// ****************************************************************
	// input synchronisers
	// ****************************************************************
	logic [`GPIO_BANK_COUNT*PINS_PER_BANK-1:0] pins_raw;
	logic [`GPIO_BANK_COUNT*PINS_PER_BANK-1:0] pins_sync;
	logic [7:0] sync_a;
	logic [7:0] sync_c;

	// bank C in the upper half, bank A in the lower half
	assign pins_raw = {pin_c_in, pin_a_in};

	// both banks pass two flops before any read
	gpio_sync #(.WIDTH(`GPIO_BANK_COUNT * PINS_PER_BANK)) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.d(pins_raw),
		.q(pins_sync)
	);

	// split the synchronised word back into banks
	assign sync_a = pins_sync[7:0];
	assign sync_c = pins_sync[15:8];

	// ****************************************************************
	// bank registers
	// ****************************************************************
	// stored words and their next values
	bank_reg_s bank_a_ff;
	bank_reg_s bank_c_ff;
	bank_reg_s nxt_bank_a;
	bank_reg_s nxt_bank_c;

	// whole-word writes
	always_comb begin
		nxt_bank_a = bank_a_ff;
		nxt_bank_c = bank_c_ff;
		// both strobes may be high together; the banks never share bits
		if (bank_wr.wr_a) begin
			nxt_bank_a = unpack_word(bank_wr.wdata, 1'h0); // bank A has no sf bits
		end
		if (bank_wr.wr_c) begin
			nxt_bank_c = unpack_word(bank_wr.wdata, 1'h1);
		end
	end

	// registers only; bank C resets with LED pin as lit output
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bank_a_ff <= `GPIO_BANK_A_RESET;
			bank_c_ff <= `GPIO_BANK_C_RESET;
		end else begin
			bank_a_ff <= nxt_bank_a;
			bank_c_ff <= nxt_bank_c;
		end
	end

	// ****************************************************************
	// pin drive and read-back
	// ****************************************************************
	// drive flops and their next values
	pin_drive_s drive_a_ff;
	pin_drive_s drive_c_ff;
	pin_drive_s nxt_drive_a;
	pin_drive_s nxt_drive_c;
	logic led_ff;
	logic nxt_led;

	// enables decoded from next register values, in step with the data bits;
	// a decode of live flops could glitch a driver on for a moment when one
	// write changes mode and direction together
	always_comb begin
		nxt_drive_a.out = nxt_bank_a.data;
		nxt_drive_a.oe = out_en(nxt_bank_a);
		nxt_drive_c.out = nxt_bank_c.data;
		nxt_drive_c.oe = out_en(nxt_bank_c);
		nxt_led = nxt_drive_c.oe[`GPIO_LED_BIT] & nxt_drive_c.out[`GPIO_LED_BIT];
	end

	// registers only; reset values agree with the bank reset words
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			drive_a_ff <= `GPIO_DRIVE_A_RESET;
			drive_c_ff <= `GPIO_DRIVE_C_RESET;
			led_ff <= `GPIO_LED_RESET;
		end else begin
			drive_a_ff <= nxt_drive_a;
			drive_c_ff <= nxt_drive_c;
			led_ff <= nxt_led;
		end
	end

	// pins follow the drive flops
	assign pin_a = drive_a_ff;
	assign pin_c = drive_c_ff;
	// special function bits for the alternate function mux outside
	assign special_c = bank_c_ff.sf;

	// ****************************************************************
	// read-back
	// ****************************************************************
	// outputs read back their own pin level, not the stored data bit
	// read words carry synchronised levels
	assign gpio_bank_a = read_word(bank_a_ff, sync_a);
	assign gpio_bank_c = read_word(bank_c_ff, sync_c);

	// ****************************************************************
	// board pins
	// ****************************************************************
	// led lit on high level while configured as output
	assign led_pin = led_ff;
	// button reads low when pressed
	// flag shows pressed in reset: sync flops start at zero for two edges
	assign button_pressed = ~sync_c[`GPIO_BUTTON_BIT];
endmodule

`default_nettype wire

// ===== verification/gpio_port_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module gpio_port_chk (
	input wire logic clk,
	input wire logic reset_n,
	input wire gpio_pkg::bank_wr_s bank_wr,
	input wire logic [31:0] gpio_bank_a,
	input wire logic [31:0] gpio_bank_c,
	input wire logic [7:0] pin_a_in,
	input wire logic [7:0] pin_c_in,
	input wire gpio_pkg::pin_drive_s pin_c,
	input wire logic led_pin,
	input wire logic button_pressed
);
	import gpio_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// reads and button lag the pins by two flops
	a_sync_read: assert property (
		$past(reset_n) && $past(reset_n, 2) |-> gpio_bank_a[7:0] == $past(pin_a_in, 2))
		else $error("read lag");
	a_button_level: assert property (
		$past(reset_n) && $past(reset_n, 2) |-> button_pressed == !$past(pin_c_in[5], 2))
		else $error("button");
	// writes land one edge later
	a_cfg_store: assert property (
		bank_wr.wr_c |=> gpio_bank_c[31:8] == $past(bank_wr.wdata[31:8])) else $error("cfg");
	a_out_drive: assert property (
		bank_wr.wr_c |=> pin_c.out == $past(bank_wr.wdata[7:0])) else $error("drive");
	a_sf_absent: assert property (gpio_bank_a[15:8] == 8'h00) else $error("sf a");
	a_oe_decode: assert property (
		pin_c.oe == (~gpio_bank_c[31:24] & gpio_bank_c[23:16] & ~gpio_bank_c[15:8]))
		else $error("oe");
	a_led_lit: assert property (led_pin == (pin_c.oe[6] & pin_c.out[6])) else $error("led");
endmodule
bind dual_bank_gpio_port gpio_port_chk chk_u (.clk, .reset_n, .bank_wr, .gpio_bank_a,
	.gpio_bank_c, .pin_a_in, .pin_c_in, .pin_c, .led_pin, .button_pressed);
`default_nettype wire

// ===== verification/gpio_board_model.sv
`timescale 1ns/1ns
`default_nettype none
module gpio_board_model (
	input wire logic pressed,
	input wire logic [7:0] ext_c,
	input wire gpio_pkg::pin_drive_s pin_c,
	output logic [7:0] pin_c_in
);
	import gpio_pkg::*;
	// wire level from enables; pulled-up button pulls low when pressed
	always_comb begin
		pin_c_in = (pin_c.oe & pin_c.out) | (~pin_c.oe & ext_c);
		if (!pin_c.oe[5]) begin
			pin_c_in[5] = !pressed;
		end
	end
endmodule
`default_nettype wire

// ===== verification/test_dual_bank_gpio_port.sv
`timescale 1ns/1ns
`default_nettype none
module test_dual_bank_gpio_port;
	import gpio_pkg::*;
	logic clk = 0, reset_n = 0, pressed = 0, led_pin, button_pressed;
	logic [7:0] ext_a = 8'h00, ext_c = 8'h00, pin_a_in, pin_c_in, special_c;
	logic [31:0] gpio_bank_a, gpio_bank_c;
	bank_wr_s bank_wr = '0;
	pin_drive_s pin_a, pin_c;
	int fails = 0, n_compared = 0;
	// bank a wire: driven or outside level
	assign pin_a_in = (pin_a.oe & pin_a.out) | (~pin_a.oe & ext_a);
	dual_bank_gpio_port dut_u (.clk, .reset_n, .bank_wr, .gpio_bank_a, .gpio_bank_c,
		.pin_a_in, .pin_a, .pin_c_in, .pin_c, .special_c, .led_pin, .button_pressed);
	gpio_board_model board_u (.pressed, .ext_c, .pin_c, .pin_c_in);
	initial forever #2 clk = ~clk;
	// hang guard
	initial begin
		#1000;
		fails++;
		report_and_stop;
	end
	task chk(string what, logic [31:0] exp, logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s exp %h got %h", what, exp, got);
		end
	endtask
	// one-cycle write, then wait out the read lag
	task wr(logic c, logic [31:0] d);
		bank_wr = {!c, c, d};
		@(posedge clk) #1;
		bank_wr = '0;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task t_reset;
		chk("cfg_a", 32'h0, gpio_bank_a[31:8]);
		chk("cfg_c", 32'h4000, gpio_bank_c[31:8]);
		chk("led", 32'h1, led_pin);
		chk("btn", 32'h0, button_pressed);
		$display("t_reset done");
	endtask
	task t_bank_a;
		ext_a = 8'h3C;
		wr(1'h0, 32'h0FFF33A5);
		chk("cfg_a", 32'h0FFF00, gpio_bank_a[31:8]);
		chk("out_a", 32'hA5, pin_a.out);
		chk("oe_a", 32'hF0, pin_a.oe);
		chk("sf_a", 32'h0, gpio_bank_a[15:8]);
		chk("rd_a", 32'hAC, gpio_bank_a[7:0]);
		$display("t_bank_a done");
	endtask
	task t_bank_c;
		pressed = 1;
		wr(1'h1, gpio_bank_c & 32'hFFFFFFBF);
		chk("cfg_c", 32'h4000, gpio_bank_c[31:8]);
		chk("led", 32'h0, led_pin);
		chk("btn", 32'h1, button_pressed);
		chk("rd_c", 32'h0, gpio_bank_c[7:0]);
		wr(1'h1, 32'h00404040);
		chk("sf_c", 32'h40, special_c);
		chk("oe_c", 32'h0, pin_c.oe);
		$display("t_bank_c done");
	endtask
	// reset in mid-run restores the lit led and released button
	task t_mid_reset;
		pressed = 0;
		ext_a = 8'h00;
		reset_n = 0;
		repeat (2) @(posedge clk);
		#1 reset_n = 1;
		repeat (3) @(posedge clk);
		#1;
		chk("cfg_a", 32'h0, gpio_bank_a[31:8]);
		chk("cfg_c", 32'h4000, gpio_bank_c[31:8]);
		chk("rd_c", 32'h60, gpio_bank_c[7:0]);
		chk("led", 32'h1, led_pin);
		chk("btn", 32'h0, button_pressed);
		$display("t_mid_reset done");
	endtask
	task report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		#1 reset_n = 1;
		repeat (3) @(posedge clk);
		#1;
		t_reset;
		t_bank_a;
		t_bank_c;
		t_mid_reset;
		report_and_stop;
	end
endmodule
`default_nettype wire
